// ### rtl/hdlc_channel_status_flags.sv
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "hdlc_status_params.svh"

module hdlc_channel_status_flags #(
  parameter int ADDR_W = 16,
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel conditions, same clock domain
  input hdlc_status_pkg::chan_in_s chanIn [CHANNELS],
  // modem pins, asynchronous, active low
  input wire logic [CHANNELS-1:0] clear_to_send_in_n,
  input wire logic [CHANNELS-1:0] carrier_detect_in_n,
  // to the framing engine
  output logic [CHANNELS-1:0] txAbortReq,
  // interrupt
  output logic irq
);

  logic [31:0] ienWord [CHANNELS];
  logic [31:0] statusWord [CHANNELS];
  logic [31:0] clrMask [CHANNELS];
  logic [CHANNELS-1:0] ienWrite;
  logic [CHANNELS-1:0] statSel;
  logic [CHANNELS-1:0] ienSel;
  logic [CHANNELS-1:0] clrSel;
  logic [CHANNELS-1:0] irqAny;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic pslverr_ff;
  logic nxt_slverr;
  logic irq_ff;
  logic [CHANNELS-1:0] txAbortReq_ff;
  logic setupPhase;
  logic commit;
  logic mapped;

  assign setupPhase = psel & ~penable;
  // transfer completes at the edge where our own ready is seen
  assign commit = psel & penable & pready_ff;

  // address decode for both channels
  always_comb
  begin
    statSel = '0;
    ienSel = '0;
    clrSel = '0;
    statSel[0] = (paddr == ADDR_W'(`STAT_A_ADDR));
    ienSel[0] = (paddr == ADDR_W'(`IEN_A_ADDR));
    clrSel[0] = (paddr == ADDR_W'(`CLR_A_ADDR));
    if (CHANNELS > 1)
    begin
      statSel[1] = (paddr == ADDR_W'(`STAT_B_ADDR));
      ienSel[1] = (paddr == ADDR_W'(`IEN_B_ADDR));
      clrSel[1] = (paddr == ADDR_W'(`CLR_B_ADDR));
    end
  end

  assign mapped = |{statSel, ienSel, clrSel};

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      // write-one clears, from the status word or its clear alias
      assign clrMask[ch] = (commit & pwrite & (statSel[ch] | clrSel[ch]))
                           ? (pwdata & `STICKY_MASK) : 32'h0000_0000;

      assign ienWrite[ch] = commit & pwrite & ienSel[ch];

      hdlc_status_channel i_hdlc_status_channel (
        .sys_clk(sys_clk),
        .srst(srst),
        .chanCond(chanIn[ch]),
        .ctsPinN(clear_to_send_in_n[ch]),
        .dcdPinN(carrier_detect_in_n[ch]),
        .clrMask(clrMask[ch]),
        .ienWrite(ienWrite[ch]),
        .wrData(pwdata),
        .statusWord(statusWord[ch]),
        .ienWord(ienWord[ch]),
        .irqReq(irqAny[ch]),
        .abortReq(txAbortReq_ff[ch])
      );
    end
  endgenerate

  // read mux; captured at setup so the data is steady in access
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (statSel[i])
        nxt_prdata = statusWord[i]; // see RULE1
      if (ienSel[i])
        nxt_prdata = ienWord[i];
    end
  end

  // clear alias is write-only; reading it is refused like a hole
  always_comb
  begin
    nxt_slverr = ~mapped;
    if (~pwrite & (|clrSel))
      nxt_slverr = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      prdata_ff <= 32'h0000_0000;
    else if (setupPhase & ~pwrite)
      prdata_ff <= nxt_prdata;
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pready_ff <= 1'b0;
    else
      pready_ff <= psel & penable & ~pready_ff;
  end

  // error rides with ready; decode is steady through the access phase
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pslverr_ff <= 1'b0;
    else
      pslverr_ff <= psel & penable & ~pready_ff & nxt_slverr;
  end

  // level interrupt, registered so it lags the flag by one cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      irq_ff <= 1'b0;
    else
      irq_ff <= |irqAny;
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign txAbortReq = txAbortReq_ff;

endmodule

module hdlc_status_channel (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // conditions from the framing engine, same clock
  input hdlc_status_pkg::chan_in_s chanCond,
  // modem pins, asynchronous, active low
  input wire logic ctsPinN,
  input wire logic dcdPinN,
  // register writes
  input wire logic [31:0] clrMask,
  input wire logic ienWrite,
  input wire logic [31:0] wrData,
  // results
  output logic [31:0] statusWord,
  output logic [31:0] ienWord,
  output logic irqReq,
  output logic abortReq
);

  logic [31:0] sticky_ff;
  logic [31:0] live_ff;
  logic [31:0] ien_ff;
  logic [3:0] count_ff;
  logic abortReq_ff;
  logic [31:0] setMask;
  logic [31:0] nxt_live;
  logic [3:0] rbMask;
  logic ctsLevelN;
  logic dcdLevelN;
  logic ctsEdge;
  logic dcdEdge;
  hdlc_status_pkg::chan_in_s c;

  assign c = chanCond;

  pin_change_filter i_cts_filter (
    .sys_clk(sys_clk),
    .srst(srst),
    .pinN(ctsPinN),
    .levelN(ctsLevelN),
    .changed(ctsEdge) // see RULE10
  );

  pin_change_filter i_dcd_filter (
    .sys_clk(sys_clk),
    .srst(srst),
    .pinN(dcdPinN),
    .levelN(dcdLevelN),
    .changed(dcdEdge) // see RULE17
  );

  assign rbMask = c.fourWordMode ? `RB_FOUR_MASK : `RB_SINGLE_MASK;

  // event sources for the held bits
  always_comb
  begin
    setMask = '0;
    setMask[`TX_FRAME_COMPLETE_FLAG_BIT] = c.txQueueEmpty
                         & (c.txClosingSent | c.txAbortSent); // see RULE6
    setMask[`CTSCHG_BIT] = ctsEdge; // see RULE10
    setMask[`TXU_BIT] = c.txRanDry; // see RULE11
    setMask[`FLAG_BIT] = c.rxFlagEnd; // see RULE15
    setMask[`DCDCHG_BIT] = dcdEdge; // see RULE17
  end

  // condition-following bits, recomputed every cycle
  always_comb
  begin
    nxt_live = '0;
    nxt_live[`TX_SPACE_AVAILABLE_BIT] = ~c.txDmaOn
      & (c.fourWordMode ? c.txFirstFourFree
                        : c.txFirstFree); // see RULE7 see RULE8
    nxt_live[`CTSLVL_BIT] = ~ctsLevelN; // see RULE9
    nxt_live[`RX_DATA_AVAILABLE_BIT] = ~c.rxDmaOn
      & (c.fourWordMode
         ? (c.rxLastFourData | (c.rxEndMarked & c.rxAnyData))
         : c.rxLastWordData); // see RULE12 see RULE13 see RULE14
    nxt_live[`DCDLVL_BIT] = ~dcdLevelN; // see RULE16
    nxt_live[`RX_FRAME_VALID_BIT] = c.rxFrameValid; // see RULE3
    nxt_live[`CRCE_BIT] = c.rxCheckError; // see RULE3
    nxt_live[`NO_BIT] = c.rxNonOctet; // see RULE3
    nxt_live[`OV_BIT] = c.rxOverrun; // see RULE3
    nxt_live[`IERR_BIT] = c.rxClockError; // see RULE3
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      live_ff <= `STAT_RST; // see RULE2
    else
      live_ff <= nxt_live; // see RULE3
  end

  // held bits: a set in the clearing cycle wins; reads touch nothing
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      sticky_ff <= `STAT_RST; // see RULE2
    else
      sticky_ff <= ((sticky_ff & ~clrMask) | setMask)
                   & `STICKY_MASK & 32'hFFFF_FFF0; // see RULE4 see RULE1
  end

  // count field: a new frame's count beats a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      count_ff <= 4'h0; // see RULE2
    else if (c.rxFrameDone)
      count_ff <= c.rxLastCount & rbMask; // see RULE5
    else
      count_ff <= count_ff & ~clrMask[`RB_MSB:`RB_LSB]; // see RULE4
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ien_ff <= `IEN_RST;
    else if (ienWrite)
      ien_ff <= wrData & `IRQ_MASK; // see RULE9 see RULE16
  end

  // abort is requested in the cycle after the frame ran dry
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      abortReq_ff <= 1'b0;
    else
      abortReq_ff <= c.txRanDry; // see RULE11
  end

  // bit 10 and the unused upper bits stay zero in every source
  assign statusWord = sticky_ff | live_ff
                      | {28'h000_0000, count_ff}; // see RULE18
  assign ienWord = ien_ff;
  assign irqReq = |(statusWord & ien_ff); // see RULE15 see RULE17
  assign abortReq = abortReq_ff;

endmodule

module pin_change_filter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // raw pin, asynchronous, active low
  input wire logic pinN,
  // accepted level and its one-cycle change strobe
  output logic levelN,
  output logic changed
);

  logic [2:0] sync_ff;
  logic level_ff;
  logic agree;

  // three stages; only stages two and three are compared
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      sync_ff <= 3'h7;
    else
      sync_ff <= {sync_ff[1:0], pinN}; // see RULE18
  end

  assign agree = (sync_ff[2] == sync_ff[1]);

  // reset to the idle level so release brings no false edge
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      level_ff <= 1'b1;
    else if (agree)
      level_ff <= sync_ff[2];
  end

  // both directions count as a change
  assign changed = agree & (sync_ff[2] != level_ff);
  assign levelN = level_ff;

endmodule

// ### rtl/hdlc_status_params.svh
// How it works
// RULE1: reads return the word, never clear flags
// RULE2: two channel words, all zero after reset
// RULE3: condition bits follow live hardware state
// RULE4: other bits stick until written one
// RULE5: low field holds last unit bytes minus one
// RULE6: tx complete when queue empty and closed
// RULE7: tx space bit follows free entries per mode
// RULE8: tx space bit zero during transmit dma
// RULE9: clear-to-send level is inverted pin, no irq
// RULE10: any clear-to-send edge sets stored flag
// RULE11: underrun requests abort and sets flag
// RULE12: rx data bit follows last entries per mode
// RULE13: four-word mode readable with end marker
// RULE14: rx data bit zero during receive dma
// RULE15: flag end sets flag-seen bit, may interrupt
// RULE16: carrier level is inverted pin, no irq
// RULE17: carrier edge sets stored flag, may interrupt
// RULE18: pins synchronised; bit 10 reads zero
`ifndef HDLC_STATUS_PARAMS_SVH
`define HDLC_STATUS_PARAMS_SVH

`define STAT_A_ADDR 16'h7008
`define STAT_B_ADDR 16'h8008
`define IEN_A_ADDR 16'h700C
`define IEN_B_ADDR 16'h800C
`define CLR_A_ADDR 16'h7010
`define CLR_B_ADDR 16'h8010

`define STAT_RST 32'h0000_0000
`define IEN_RST 32'h0000_0000

`define RB_LSB 0
`define RB_MSB 3
`define TX_FRAME_COMPLETE_FLAG_BIT 4
`define TX_SPACE_AVAILABLE_BIT 5
`define CTSLVL_BIT 6
`define CTSCHG_BIT 7
`define TXU_BIT 8
`define RX_DATA_AVAILABLE_BIT 9
`define FLAG_BIT 11
`define DCDLVL_BIT 12
`define DCDCHG_BIT 13
`define RX_FRAME_VALID_BIT 14
`define CRCE_BIT 17
`define NO_BIT 18
`define OV_BIT 19
`define IERR_BIT 23

`define STICKY_MASK 32'h0000_299F
`define IRQ_MASK 32'h008E_6BB0
`define RB_SINGLE_MASK 4'h3
`define RB_FOUR_MASK 4'hF

`endif

// ### rtl/hdlc_status_pkg.sv
package hdlc_status_pkg;

  // per-channel conditions from the framing engine and queues
  typedef struct packed {
    logic fourWordMode;
    logic txQueueEmpty;
    logic txFirstFree;
    logic txFirstFourFree;
    logic txClosingSent;
    logic txAbortSent;
    logic txRanDry;
    logic txDmaOn;
    logic rxLastWordData;
    logic rxLastFourData;
    logic rxAnyData;
    logic rxEndMarked;
    logic rxDmaOn;
    logic rxFrameDone;
    logic [3:0] rxLastCount;
    logic rxFlagEnd;
    logic rxFrameValid;
    logic rxCheckError;
    logic rxNonOctet;
    logic rxClockError;
    logic rxOverrun;
  } chan_in_s;

  typedef logic [31:0] word_t;

endpackage

// ### bench/status_chk.sv
`timescale 1ns/1ns
module status_chk #(
  parameter int ADDR_W = 16,
  parameter int CHANNELS = 2
) (
  // clock and reset
  input logic sys_clk,
  input logic srst,
  // apb
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  // framing side
  input hdlc_status_pkg::chan_in_s chanIn [CHANNELS],
  input logic [CHANNELS-1:0] txAbortReq,
  input logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_ready_second: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("late pready");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("long pready");
  chk_abort_follow: assert property (chanIn[0].txRanDry |=> txAbortReq[0])
    else $error("no abort");
  chk_abort_cause: assert property (txAbortReq[1] |-> $past(chanIn[1].txRanDry))
    else $error("stray abort");
  chk_bit_ten: assert property (pready && !pwrite |-> !prdata[10])
    else $error("bit ten set");
  chk_rx_dma: assert property (pready && !pwrite && paddr == 16'h7008
    && $past(chanIn[0].rxDmaOn, 3) |-> !prdata[9]) else $error("rx bit in dma");
  chk_tx_dma: assert property (pready && !pwrite && paddr == 16'h8008
    && $past(chanIn[1].txDmaOn, 3) |-> !prdata[5]) else $error("tx bit in dma");
  chk_irq_fall: assert property ($fell(irq) |-> $past(pready && pwrite, 2))
    else $error("irq fell without write");
endmodule

bind hdlc_channel_status_flags status_chk #(.ADDR_W(ADDR_W), .CHANNELS(CHANNELS))
  i_chk (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .chanIn(chanIn), .txAbortReq(txAbortReq), .irq(irq));

// ### bench/modem_side.sv
`timescale 1ns/1ns
module modem_side (
  // clock
  input logic sys_clk,
  // toggle requests: cts a, cts b, carrier a, carrier b
  input logic [3:0] flip,
  // pins, pulled up while idle
  output logic [1:0] ctsN,
  output logic [1:0] dcdN
);
  initial {dcdN, ctsN} = 4'hF;
  always @(posedge sys_clk)
  begin
    {dcdN, ctsN} <= {dcdN, ctsN} ^ flip;
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 0;
  logic srst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, lastErr, irq;
  logic [1:0] ctsN, dcdN, txAbortReq;
  logic [3:0] flip = '0;
  hdlc_status_pkg::chan_in_s chanIn [2];
  hdlc_status_pkg::chan_in_s c;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int r;

  always #4 sys_clk = ~sys_clk;

  hdlc_channel_status_flags i_hdlc_channel_status_flags (.sys_clk(sys_clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chanIn(chanIn), .clear_to_send_in_n(ctsN),
    .carrier_detect_in_n(dcdN), .txAbortReq(txAbortReq), .irq(irq));
  modem_side i_modem_side (.sys_clk(sys_clk), .flip(flip), .ctsN(ctsN),
    .dcdN(dcdN));

  function automatic logic [31:0] live(hdlc_status_pkg::chan_in_s v);
    live = '0;
    live[5] = !v.txDmaOn && (v.fourWordMode ? v.txFirstFourFree : v.txFirstFree);
    live[9] = !v.rxDmaOn && (v.fourWordMode ? (v.rxLastFourData
      || (v.rxEndMarked && v.rxAnyData)) : v.rxLastWordData);
    live[23:14] = {v.rxClockError, 3'h0, v.rxOverrun, v.rxNonOctet,
      v.rxCheckError, 2'h0, v.rxFrameValid};
  endfunction

  task summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ends one edge after release so psel is never driven twice in a step
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task rc(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check("status", q & m, e);
  endtask

  task irqIs(input logic e);
    @(posedge sys_clk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  // closing flag, underrun, frame done with count, flag end
  task pulse(input int ch, input logic [3:0] n);
    hdlc_status_pkg::chan_in_s s;
    s = chanIn[ch];
    chanIn[ch] <= s | {8'h0A, 4'h0, 2'h1, n, 6'h20};
    @(posedge sys_clk);
    chanIn[ch] <= s;
  endtask

  initial
  begin
    chanIn[0] = 24'h40_0000;
    chanIn[1] = 24'h80_0000;
    void'($urandom(99608));
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rc(16'h7008, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(16'h8008, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, 16'h700C, 32'h0000_0800);
    pulse(0, 4'hF);
    @(posedge sys_clk);
    irqIs(1'b1);
    rc(16'h7008, 32'hFFFF_FFFF, 32'h0000_0913);
    apb(1'b1, 16'h7008, 32'h0000_0000);
    rc(16'h7008, 32'hFFFF_FFFF, 32'h0000_0913);
    apb(1'b1, 16'h7008, 32'h0000_0010);
    rc(16'h7008, 32'hFFFF_FFFF, 32'h0000_0903);
    apb(1'b1, 16'h700C, 32'h0000_0000);
    irqIs(1'b0);
    apb(1'b1, 16'h7010, 32'hFFFF_FFFF);
    rc(16'h7008, 32'hFFFF_FFFF, 32'h0000_0000);
    pulse(1, 4'hF);
    rc(16'h8008, 32'hFFFF_FFFF, 32'h0000_090F);
    apb(1'b0, 16'h7000, 32'h0000_0000);
    check("pslverr", {31'h0, lastErr}, 32'h0000_0001);
    for (int k = 0; k < 2; k++)
    begin
      flip <= 4'h9;
      @(posedge sys_clk);
      flip <= 4'h0;
      repeat (6) @(posedge sys_clk);
      rc(16'h7008, 32'h0000_30C0, k ? 32'h0000_0080 : 32'h0000_00C0);
      rc(16'h8008, 32'h0000_30C0, k ? 32'h0000_2000 : 32'h0000_3000);
    end
    repeat (24)
    begin
      r = $urandom % 2;
      c = hdlc_status_pkg::chan_in_s'(24'($urandom) & 24'hF1_F81F);
      chanIn[r] <= c;
      @(posedge sys_clk);
      rc(r ? 16'h8008 : 16'h7008, 32'h008E_4620, live(c));
    end
    summarize();
  end

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      summarize();
    end
  end
endmodule
